/* verilog/ssio_pkg.sv */
// Shared constants, register map and types of the serial shift unit
package ssio_pkg;
    // Bus geometry
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int SHW = 8;

    // Timing: system clock, instruction clock and peer shift clock half period
    localparam int CLK_MHZ = 50;
    localparam int INSTR_CLK_NS = 80;
    localparam int INSTR_CLK_CYC = (INSTR_CLK_NS * CLK_MHZ) / 1000;
    localparam int PEER_HALF_NS = 100;
    localparam logic [4:0] PEER_HALF = 5'((PEER_HALF_NS * CLK_MHZ) / 1000);

    // Shift clock half periods for the three internal rates
    localparam logic [4:0] HALF_DIV8 = 5'(INSTR_CLK_CYC * 8 / 2);
    localparam logic [4:0] HALF_DIV4 = 5'(INSTR_CLK_CYC * 4 / 2);
    localparam logic [4:0] HALF_DIV2 = 5'(INSTR_CLK_CYC * 2 / 2);

    // Register offsets
    localparam logic [AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AW-1:0] REG_ACC = 8'h04;
    localparam logic [AW-1:0] REG_CMD = 8'h08;
    localparam logic [AW-1:0] REG_SHIFT = 8'h0c;
    localparam logic [AW-1:0] REG_STATUS = 8'h10;
    localparam logic [AW-1:0] REG_IRQ_STAT = 8'h14;
    localparam logic [AW-1:0] REG_IRQ_MASK = 8'h18;

    // Control register fields
    localparam int CTRL_CKS_LSB = 0;
    localparam int CTRL_IRQ_EN = 2;
    localparam int CTRL_LINE_LOW = 3;
    localparam logic [1:0] CKS_EXT = 2'h3;
    localparam logic [1:0] CKS_RESET = 2'h0;

    // Command register bits (write only, self clearing)
    localparam int CMD_LOAD = 0;
    localparam int CMD_BEGIN = 1;
    localparam int CMD_SKIP = 2;
    localparam int CMD_INT_TAKEN = 3;

    // Status register bits
    localparam int ST_DONE = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_SKIP = 2;
    localparam int ST_LINE = 3;
    localparam int ST_ARMED = 4;

    // Interrupt status / mask bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_READY = 1;
    localparam int IRQ_W = 2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_XFER = 2'b11
    } ssio_state_t;

    // Half period in system clocks for a clock select code
    function automatic logic [4:0] ssio_half(input logic [1:0] sel);
        case (sel)
            2'h0:    return HALF_DIV8;
            2'h1:    return HALF_DIV4;
            default: return HALF_DIV2;
        endcase
    endfunction
endpackage

/* verilog/ssio_if.sv */
// Link between the shift unit and its peer: clock, data and control lines
`timescale 1ns/1ns
interface ssio_if;
    logic dev_sck_o;
    logic dev_sck_oe_n;
    logic peer_sck_o;
    logic peer_sck_oe_n;
    logic dev_sout;
    logic peer_sout;
    logic dev_ctrl_o;
    logic dev_ctrl_oe_n;
    logic peer_ctrl_o;
    logic peer_ctrl_oe_n;
    logic sck;
    logic ctrl;

    // Shift clock idles high through a pull-up when nobody drives it
    assign sck = !dev_sck_oe_n ? dev_sck_o : (!peer_sck_oe_n ? peer_sck_o : 1'b1);
    // Control line is open drain with a pull-up
    assign ctrl = !((!dev_ctrl_oe_n && !dev_ctrl_o) || (!peer_ctrl_oe_n && !peer_ctrl_o));

    modport dev (
        output dev_sck_o, dev_sck_oe_n, dev_sout, dev_ctrl_o, dev_ctrl_oe_n,
        input  sck, peer_sout, ctrl
    );
    modport peer (
        output peer_sck_o, peer_sck_oe_n, peer_sout, peer_ctrl_o, peer_ctrl_oe_n,
        input  sck, dev_sout, ctrl
    );
endinterface

/* verilog/ssio_shifter.sv */
// Eight bit LSB-first shift register with bit counter
`timescale 1ns/1ns
module ssio_shifter (
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire logic                     load,
    input  wire logic [ssio_pkg::SHW-1:0] load_data,
    input  wire logic                     fall_ev,
    input  wire logic                     rise_ev,
    input  wire logic                     sin,
    output logic      [ssio_pkg::SHW-1:0] data,
    output logic                          sout,
    output logic                          last
);
    import ssio_pkg::*;

    logic [3:0] count_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data <= 8'h00;
            count_reg <= 4'h0;
        end else if (load) begin
            data <= load_data;
            count_reg <= 4'h0;
        end else if (rise_ev) begin
            data <= {sin, data[SHW-1:1]};
            count_reg <= count_reg + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sout <= 1'b1;
        end else if (fall_ev) begin
            sout <= data[0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last <= 1'b0;
        end else begin
            last <= rise_ev && (count_reg == 4'h7);
        end
    end
endmodule

/* verilog/ssio_peer.sv */
// Peer microcomputer end: master or slave of the shift link with handshake
`timescale 1ns/1ns
module ssio_peer (
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire logic                     role_master,
    input  wire logic [ssio_pkg::SHW-1:0] tx_data,
    input  wire logic                     start,
    output logic      [ssio_pkg::SHW-1:0] rx_data,
    output logic                          done,
    output logic                          busy,
    ssio_if.peer                          bus
);
    import ssio_pkg::*;

    ssio_state_t          state_reg;
    logic [4:0]           hc_reg;
    logic                 sck_reg;
    logic                 sck_oe_n_reg;
    logic                 sck_in_reg;
    logic                 sck_prev_reg;
    logic                 sin_reg;
    logic                 ctrl_in_reg;
    logic                 seen_high_reg;
    logic                 ctrl_oe_n_reg;
    logic                 tick;
    logic                 fall_ev;
    logic                 rise_ev;
    logic                 sh_last;
    logic                 sh_sout;
    logic [SHW-1:0]       sh_data;

    assign tick = (state_reg == ST_XFER) && role_master && (hc_reg == PEER_HALF - 5'h1);
    assign fall_ev = (state_reg != ST_IDLE) &&
                     (role_master ? (tick && sck_reg) : (sck_prev_reg && !sck_in_reg));
    assign rise_ev = (state_reg != ST_IDLE) &&
                     (role_master ? (tick && !sck_reg) : (!sck_prev_reg && sck_in_reg));

    ssio_shifter u_shift (
        .clk       (clk),
        .arst_n    (arst_n),
        .load      (start && (state_reg == ST_IDLE)),
        .load_data (tx_data),
        .fall_ev   (fall_ev),
        .rise_ev   (rise_ev),
        .sin       (sin_reg),
        .data      (sh_data),
        .sout      (sh_sout),
        .last      (sh_last)
    );

    assign bus.peer_sck_o = sck_reg;
    assign bus.peer_sck_oe_n = sck_oe_n_reg;
    assign bus.peer_sout = sh_sout;
    assign bus.peer_ctrl_o = 1'b0;
    assign bus.peer_ctrl_oe_n = ctrl_oe_n_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_in_reg <= 1'b1;
            sck_prev_reg <= 1'b1;
            sin_reg <= 1'b1;
            ctrl_in_reg <= 1'b1;
            sck_oe_n_reg <= 1'b1;
        end else begin
            sck_in_reg <= bus.sck;
            sck_prev_reg <= sck_in_reg;
            sin_reg <= bus.dev_sout;
            ctrl_in_reg <= bus.ctrl;
            sck_oe_n_reg <= !role_master;
        end
    end

    // Master clock: held high outside the eight pulses
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hc_reg <= 5'h0;
            sck_reg <= 1'b1;
        end else if (state_reg == ST_XFER && role_master) begin
            if (tick) begin
                hc_reg <= 5'h0;
                sck_reg <= !sck_reg;
            end else begin
                hc_reg <= hc_reg + 5'h1;
            end
        end else begin
            hc_reg <= 5'h0;
            sck_reg <= 1'b1;
        end
    end

    // A fresh low only counts after the line has been seen high again
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_high_reg <= 1'b0;
        end else if (ctrl_in_reg) begin
            seen_high_reg <= 1'b1;
        end else if (state_reg == ST_WAIT && role_master) begin
            seen_high_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            ctrl_oe_n_reg <= 1'b1;
            done <= 1'b0;
            busy <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            done <= 1'b0;
            busy <= (state_reg != ST_IDLE);
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_WAIT;
                        ctrl_oe_n_reg <= role_master;
                    end
                end
                ST_WAIT: begin
                    if (role_master) begin
                        if (!ctrl_in_reg && seen_high_reg) begin
                            state_reg <= ST_XFER;
                        end
                    end else if (fall_ev) begin
                        state_reg <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (sh_last) begin
                        state_reg <= ST_IDLE;
                        ctrl_oe_n_reg <= 1'b1;
                        done <= 1'b1;
                        rx_data <= sh_data;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

/* verilog/ssio_device.sv */
// Serial shift unit with APB registers, internal or external shift clock
//
// Functional notes
// - Load puts A low, B high nibble (here all eight bits are loaded from the ACC register)
// - Begin starts transfer and clears done flag
// - Output bits change on falling shift edges
// - LSB first, register shifts toward LSB
// - Input sampled on rising shift edges
// - Received bit enters the MSB
// - Interrupt taken, or skip with interrupt disabled, clears done flag
// - External clock: begin only arms the unit
// - Master holds clock high while slave loads
// - Armed slave pulls control line low
// - Master checks control low before begin
// - Slave releases control line after receive
// - Master waits for next low indication
// - Done flag set when transfer completes
// - Internal clock gives exactly eight pulses
// - Select divides by 8, 4, 2 or external
// - Skip tests flag only when interrupt disabled
`timescale 1ns/1ns
module ssio_device (
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ssio_pkg::AW-1:0] paddr,
    input  wire logic [ssio_pkg::DW-1:0] pwdata,
    output logic      [ssio_pkg::DW-1:0] prdata,
    output logic                         pready,
    output logic                         pslverr,
    output logic                         irq,
    ssio_if.dev                          bus
);
    import ssio_pkg::*;

    ssio_state_t          state_reg;
    logic [1:0]           clk_sel_reg;
    logic                 irq_en_reg;
    logic                 ctrl_oe_n_reg;
    logic [SHW-1:0]       acc_reg;
    logic                 flag_reg;
    logic                 skip_reg;
    logic [4:0]           hc_reg;
    logic                 sck_reg;
    logic                 sck_oe_n_reg;
    logic                 sck_in_reg;
    logic                 sck_prev_reg;
    logic                 sin_reg;
    logic                 ctrl_in_reg;
    logic                 ctrl_prev_reg;
    logic [IRQ_W-1:0]     irq_stat_reg;
    logic [IRQ_W-1:0]     irq_mask_reg;
    logic [DW-1:0]        rdata_next;
    logic                 setup;
    logic                 wr_en;
    logic                 cmd_load;
    logic                 cmd_begin;
    logic                 cmd_skip;
    logic                 cmd_taken;
    logic                 ext_clk;
    logic                 tick;
    logic                 fall_ev;
    logic                 rise_ev;
    logic                 sh_last;
    logic                 sh_sout;
    logic [SHW-1:0]       sh_data;
    logic [IRQ_W-1:0]     irq_events;

    function automatic logic addr_ok(input logic [AW-1:0] a);
        case (a)
            REG_CTRL, REG_ACC, REG_CMD, REG_SHIFT,
            REG_STATUS, REG_IRQ_STAT, REG_IRQ_MASK: return 1'b1;
            default:                                return 1'b0;
        endcase
    endfunction

    // Bus decode: effects take place at the access edge
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready && addr_ok(paddr);
    assign cmd_load = wr_en && (paddr == REG_CMD) && pwdata[CMD_LOAD];
    assign cmd_begin = wr_en && (paddr == REG_CMD) && pwdata[CMD_BEGIN];
    assign cmd_skip = wr_en && (paddr == REG_CMD) && pwdata[CMD_SKIP];
    assign cmd_taken = wr_en && (paddr == REG_CMD) && pwdata[CMD_INT_TAKEN];

    assign ext_clk = (clk_sel_reg == CKS_EXT);
    assign tick = (state_reg == ST_XFER) && !ext_clk &&
                  (hc_reg == ssio_half(clk_sel_reg) - 5'h1);
    // Edges only act while a transfer is armed or running
    assign fall_ev = (state_reg != ST_IDLE) &&
                     (ext_clk ? (sck_prev_reg && !sck_in_reg) : (tick && sck_reg));
    assign rise_ev = (state_reg != ST_IDLE) &&
                     (ext_clk ? (!sck_prev_reg && sck_in_reg) : (tick && !sck_reg));

    ssio_shifter u_shift (
        .clk       (clk),
        .arst_n    (arst_n),
        .load      (cmd_load && (state_reg == ST_IDLE)),
        .load_data (acc_reg),
        .fall_ev   (fall_ev),
        .rise_ev   (rise_ev),
        .sin       (sin_reg),
        .data      (sh_data),
        .sout      (sh_sout),
        .last      (sh_last)
    );

    assign bus.dev_sck_o = sck_reg;
    assign bus.dev_sck_oe_n = sck_oe_n_reg;
    assign bus.dev_sout = sh_sout;
    assign bus.dev_ctrl_o = 1'b0;
    assign bus.dev_ctrl_oe_n = ctrl_oe_n_reg;

    // Pin samples; inputs are synchronous to clk
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_in_reg <= 1'b1;
            sck_prev_reg <= 1'b1;
            sin_reg <= 1'b1;
            ctrl_in_reg <= 1'b1;
            ctrl_prev_reg <= 1'b1;
            sck_oe_n_reg <= 1'b1;
        end else begin
            sck_in_reg <= bus.sck;
            sck_prev_reg <= sck_in_reg;
            sin_reg <= bus.peer_sout;
            ctrl_in_reg <= bus.ctrl;
            ctrl_prev_reg <= ctrl_in_reg;
            sck_oe_n_reg <= ext_clk;
        end
    end

    // Internal shift clock: eight pulses per transfer, high otherwise
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hc_reg <= 5'h0;
            sck_reg <= 1'b1;
        end else if (state_reg == ST_XFER && !ext_clk) begin
            if (tick) begin
                hc_reg <= 5'h0;
                sck_reg <= !sck_reg;
            end else begin
                hc_reg <= hc_reg + 5'h1;
            end
        end else begin
            hc_reg <= 5'h0;
            sck_reg <= 1'b1;
        end
    end

    // Transfer sequencing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_begin) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!ext_clk || fall_ev) begin
                        state_reg <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (sh_last) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Done flag: completion wins over any clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg <= 1'b0;
        end else if (sh_last) begin
            flag_reg <= 1'b1;
        end else if (cmd_begin && state_reg == ST_IDLE) begin
            flag_reg <= 1'b0;
        end else if (cmd_taken || (cmd_skip && !irq_en_reg)) begin
            flag_reg <= 1'b0;
        end
    end

    // Skip result; with the interrupt enabled the skip clears it to 0 and leaves the done flag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            skip_reg <= 1'b0;
        end else if (cmd_skip) begin
            skip_reg <= !irq_en_reg && flag_reg;
        end
    end

    // Software-written configuration
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_sel_reg <= CKS_RESET;
            irq_en_reg <= 1'b0;
            ctrl_oe_n_reg <= 1'b1;
            acc_reg <= 8'h00;
            irq_mask_reg <= 2'h0;
        end else if (wr_en) begin
            case (paddr)
                REG_CTRL: begin
                    clk_sel_reg <= pwdata[CTRL_CKS_LSB +: 2];
                    irq_en_reg <= pwdata[CTRL_IRQ_EN];
                    ctrl_oe_n_reg <= !pwdata[CTRL_LINE_LOW];
                end
                REG_ACC: begin
                    acc_reg <= pwdata[SHW-1:0];
                end
                REG_IRQ_MASK: begin
                    irq_mask_reg <= pwdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    assign irq_events = {ctrl_prev_reg && !ctrl_in_reg, sh_last};
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_reg <= 2'h0;
            irq <= 1'b0;
        end else begin
            if (wr_en && paddr == REG_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_events;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_events;
            end
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (paddr)
            REG_CTRL: begin
                rdata_next[CTRL_CKS_LSB +: 2] = clk_sel_reg;
                rdata_next[CTRL_IRQ_EN] = irq_en_reg;
                rdata_next[CTRL_LINE_LOW] = !ctrl_oe_n_reg;
            end
            REG_ACC:      rdata_next[SHW-1:0] = acc_reg;
            REG_SHIFT:    rdata_next[SHW-1:0] = sh_data;
            REG_STATUS: begin
                rdata_next[ST_DONE] = flag_reg;
                rdata_next[ST_BUSY] = (state_reg != ST_IDLE);
                rdata_next[ST_SKIP] = skip_reg;
                rdata_next[ST_LINE] = ctrl_in_reg;
                rdata_next[ST_ARMED] = (state_reg == ST_WAIT);
            end
            REG_IRQ_STAT: rdata_next[IRQ_W-1:0] = irq_stat_reg;
            REG_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask_reg;
            default:      rdata_next = 32'h0000_0000;
        endcase
    end

    // APB slave: one wait-free access phase after each setup cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !addr_ok(paddr);
            prdata <= (setup && !pwrite) ? rdata_next : 32'h0000_0000;
        end
    end
endmodule

/* testbench/ssio_chk.sv */
// Link checker: shift clock shape, data timing and control handshake
`timescale 1ns/1ns
module ssio_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic dev_sck_oe_n,
    input wire logic peer_sck_oe_n,
    input wire logic dev_sout,
    input wire logic sck,
    input wire logic ctrl
);
    logic [3:0] fall_cnt_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Shift clock falls seen while the control line is held low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) fall_cnt_reg <= 4'h0;
        else if (ctrl) fall_cnt_reg <= 4'h0;
        else if ($fell(sck)) fall_cnt_reg <= fall_cnt_reg + 4'h1;
    end

    sout_on_fall_a: assert property ($changed(dev_sout) |-> !sck)
        else $error("device data changed while shift clock high");
    sck_one_drv_a: assert property (dev_sck_oe_n || peer_sck_oe_n)
        else $error("two drivers on shift clock");
    sck_high_min_a: assert property ($rose(sck) |-> sck[*3])
        else $error("shift clock high phase too short");
    sck_low_max_a: assert property ($fell(sck) |-> !sck[*3] ##[1:14] sck)
        else $error("shift clock low phase out of range");
    master_ctrl_a: assert property ($fell(sck) && !peer_sck_oe_n |-> !ctrl)
        else $error("peer clocked without control line low");
    ctrl_fall_a: assert property ($fell(ctrl) |-> sck)
        else $error("shift clock low when control line fell");
    idle_high_a: assert property (!dev_sck_oe_n && ctrl |-> sck)
        else $error("internal shift clock not idle high");
    pulse_cnt_a: assert property (fall_cnt_reg <= 4'h8)
        else $error("more than eight shift clock pulses");

    cover property ($fell(sck) && !peer_sck_oe_n);
    cover property ($fell(sck) && !dev_sck_oe_n);
    cover property ($rose(ctrl));
endmodule

/* testbench/tb_top.sv */
// Testbench: device and peer joined over the link, device driven over APB
`timescale 1ns/1ns
module tb_top;
    import ssio_pkg::*;
    logic           clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic           role_master = 0, start = 0, pready, pslverr, irq, done, busy, err;
    logic [AW-1:0]  paddr = '0;
    logic [DW-1:0]  pwdata = '0, prdata, rd;
    logic [SHW-1:0] tx_data = '0, rx_data;
    int             n_fail = 0, n_compared = 0, falls = 0, low_n = 0, low_len = 0, f0;

    ssio_if lnk ();
    ssio_device ssio_device_i (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .bus(lnk.dev));
    ssio_peer ssio_peer_i (.clk(clk), .arst_n(arst_n), .role_master(role_master),
        .tx_data(tx_data), .start(start), .rx_data(rx_data), .done(done), .busy(busy),
        .bus(lnk.peer));
    ssio_chk ssio_chk_i (.clk(clk), .arst_n(arst_n), .dev_sck_oe_n(lnk.dev_sck_oe_n),
        .peer_sck_oe_n(lnk.peer_sck_oe_n), .dev_sout(lnk.dev_sout), .sck(lnk.sck),
        .ctrl(lnk.ctrl));

    always #10 clk = ~clk;

    // Counts completed low phases of the shift clock and keeps the last length
    always @(posedge clk) begin
        if (lnk.sck === 1'b0) low_n <= low_n + 1;
        else if (low_n != 0) begin
            falls <= falls + 1;
            low_len <= low_n;
            low_n <= 0;
        end
    end

    task automatic wrap_up();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_for(ref logic s);
        int k;
        k = 0;
        while (s !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        if (s !== 1'b1) begin
            cmp(0, 1);
            wrap_up();
        end
    endtask

    // Request stands until pready is seen high at a rising edge; answer taken there
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        int k;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 2000);
        if (pready !== 1'b1) begin
            cmp(0, 1);
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        apb(1, a, d);
    endtask

    task automatic rdm(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
        apb(0, a, 0);
        cmp(rd & m, e);
    endtask

    task automatic pulse_start(input logic [SHW-1:0] d);
        @(posedge clk);
        tx_data <= d;
        start <= 1;
        @(posedge clk);
        start <= 0;
    endtask

    task automatic reset_check();
        rdm(REG_CTRL, 32'hf, 32'h0);
        rdm(REG_STATUS, 32'h1f, 32'h8);
        apb(0, 8'h1c, 32'h5);
        cmp(32'(err), 1);
        cmp(rd, 0);
        wr(REG_IRQ_MASK, 32'h1);
    endtask

    task automatic dev_master();
        for (int i = 0; i < 3; i++) begin
            wr(REG_CTRL, i);
            wr(REG_ACC, 32'ha5 ^ i);
            wr(REG_CMD, 32'h1);
            rdm(REG_SHIFT, 32'hff, 32'ha5 ^ i);
            pulse_start(8'h3c + i);
            rdm(REG_STATUS, 32'h8, 32'h0);
            cmp(32'(busy), 1);
            wr(REG_CMD, 32'h2);
            f0 = falls;
            rdm(REG_STATUS, 32'h3, 32'h2);
            wait_for(irq);
            rdm(REG_STATUS, 32'h1, 32'h1);
            cmp(32'(falls - f0), 8);
            cmp(32'(low_len), 32'(HALF_DIV8) >> i);
            rdm(REG_SHIFT, 32'hff, 32'h3c + i);
            cmp(32'(rx_data), 32'ha5 ^ i);
            wr(REG_IRQ_STAT, 32'h1);
        end
        wr(REG_CMD, 32'h4);
        rdm(REG_STATUS, 32'h5, 32'h4);
    endtask

    task automatic peer_master();
        wr(REG_CTRL, 32'hb);
        wr(REG_ACC, 32'h96);
        wr(REG_CMD, 32'h1);
        wr(REG_CMD, 32'h2);
        f0 = falls;
        rdm(REG_STATUS, 32'h11, 32'h10);
        cmp(32'(falls - f0), 0);
        role_master <= 1;
        pulse_start(8'h69);
        wait_for(done);
        cmp(32'(rx_data), 32'h96);
        wait_for(irq);
        cmp(32'(busy), 0);
        rdm(REG_SHIFT, 32'hff, 32'h69);
        cmp(32'(falls - f0), 8);
        wr(REG_CTRL, 32'h7);
        wr(REG_CMD, 32'h4);
        rdm(REG_STATUS, 32'h5, 32'h1);
        wr(REG_CMD, 32'h8);
        rdm(REG_STATUS, 32'h1, 32'h0);
    endtask

    task automatic irq_check();
        rdm(REG_IRQ_STAT, 32'h3, 32'h3);
        cmp(32'(irq), 1);
        wr(REG_IRQ_MASK, 32'h0);
        rdm(REG_IRQ_MASK, 32'h3, 32'h0);
        cmp(32'(irq), 0);
        wr(REG_IRQ_MASK, 32'h1);
        wr(REG_IRQ_STAT, 32'h3);
        rdm(REG_IRQ_STAT, 32'h3, 32'h0);
        cmp(32'(irq), 0);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1;
        reset_check();
        dev_master();
        peer_master();
        irq_check();
        wrap_up();
    end
endmodule
